// ===== rtl/pse_cfg_pkg.sv
// constants, register map and state types of the port configuration bank
package pse_cfg_pkg;
  localparam logic [7:0] HW_FLAG_ADDR = 8'h1c;
  localparam logic [7:0] WD_TIME_ADDR = 8'h1e;
  localparam logic [7:0] WD_SWITCH_ADDR = 8'h1f;
  localparam logic [7:0] PROGRAM_ADDR = 8'h23;
  localparam logic [7:0] PWM_ADDR = 8'h24;
  localparam logic [7:0] MISC_TWO_ADDR = 8'h29;
  localparam logic [7:0] CUR_LIMIT_ADDR = 8'h2a;

  // writable (including internally connected) bits of each register
  localparam logic [7:0] WD_SWITCH_MASK = 8'hc1;
  localparam logic [7:0] PROGRAM_MASK = 8'hf7;
  localparam logic [7:0] PWM_MASK = 8'h3f;
  localparam logic [7:0] MISC_TWO_MASK = 8'h1c;
  localparam logic [7:0] CUR_LIMIT_MASK = 8'h07;

  localparam int WD_ENABLE_BIT = 7;
  localparam int EXPIRY_IRQ_BIT = 6;
  localparam int EXPIRY_MODE_BIT = 0;
  localparam int LARGE_CAP_BIT = 5;
  localparam int DET_SKIP_BIT = 4;
  localparam int AC_DISCONNECT_THRESHOLD_LSB = 0;
  localparam int DUTY_LSB = 4;
  localparam int LOAD_CHECK_BIT = 4;

  localparam logic [7:0] WD_SWITCH_RESET = 8'h00;
  localparam logic [7:0] PROGRAM_RESET = 8'h04;
  localparam logic [7:0] PWM_RESET = 8'h00;
  localparam logic [7:0] MISC_TWO_RESET = 8'h00;
  localparam logic [7:0] CUR_LIMIT_RESET = 8'h00;

  localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
  localparam logic [1:0] MODE_AUTO = 2'b11;

  // ac threshold in units of 10 nA: 85.28 uA + 10.64 uA per step
  localparam logic [15:0] AC_DISCONNECT_THRESHOLD_BASE = 16'd8528;
  localparam logic [15:0] AC_DISCONNECT_THRESHOLD_STEP = 16'd1064;

  localparam longint CLK_HZ = 125000000;
  localparam longint WD_INTERVAL_MS = 164;
  localparam int unsigned WD_TICK_CYCLES = int'(CLK_HZ * WD_INTERVAL_MS / 1000);

  typedef struct packed {
    logic [7:0] wd_switch;
    logic [7:0] wd_time;
    logic [7:0] program_cfg;
    logic [7:0] pwm;
    logic [7:0] misc_two;
    logic [7:0] cur_limit;
  } cfg_s;

  typedef struct packed {
    cfg_s cfg;
    logic [24:0] tick_cnt;
    logic hw_mode;
    logic hw_control_flag;
    logic [1:0] legacy_sync;
    logic [7:0] rdata;
    logic irq;
    logic mode_load;
    logic [1:0] port_mode;
    logic power_on;
    logic power_allow;
    logic ac_present;
    logic [9:0] limit_ma;
    logic [9:0] overcurrent_ma;
  } state_s;
endpackage

// ===== rtl/pse_port_config_registers.sv
// configuration register bank and watchdog of a single-port power-sourcing controller
// Notes on behaviour
// - watchdog acts on the port only while its enable bit 7 is set
// - bit 6 enables the interrupt driven by the hardware-control flag
// - on expiry port goes to auto if bit 0 is one, else shutdown
// - expiry loads mode code 00 for shutdown, 11 for auto
// - enabled watchdog counter decrements toward zero every 164 ms; zero means expiry
// - interrupt asserts whenever the hardware-control flag is set and enabled
// - program register resets to threshold 100, other defined bits zero
// - program bit 5 enables large-capacitor detection, by software or the select input
// - with skip bit clear, auto mode refuses power when detection was bypassed
// - bits 2:0 set ac threshold 85.28 uA plus 10.64 uA per step
// - ac presence reported only when sensed peaks exceed the threshold
// - pwm bits 5:4 pick duty 6.25/12.5/18.75/25 percent, reset zero
// - misc register bit 4 enables load stability check, reset zero
// - current-limit select loaded by classification or software, reset zero
// - select code maps to limit and overcurrent values; code 100 unused
`timescale 1ns/100ps
module pse_port_config_registers #(
  parameter int unsigned WD_TICK = pse_cfg_pkg::WD_TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register access from the serial engine
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // port control logic
  input wire logic high_cap_sel_i,
  input wire logic power_on_req_i,
  input wire logic det_bypassed_i,
  input wire logic class_load_i,
  input wire logic [2:0] class_code_i,
  input wire logic ac_peak_valid_i,
  input wire logic [15:0] ac_peak_i,
  // configuration and results
  output logic irq_o,
  output logic port_mode_load_o,
  output logic [1:0] port_mode_o,
  output logic power_on_o,
  output logic power_allow_o,
  output logic ac_present_o,
  output logic watchdog_enable_o,
  output logic large_cap_detect_enable_o,
  output logic [1:0] limit_duty_select_o,
  output logic load_stability_check_enable_o,
  output logic [9:0] current_limit_ma_o,
  output logic [9:0] overcurrent_ma_o
);
  import pse_cfg_pkg::*;

  localparam logic [24:0] TICK_LAST = 25'(WD_TICK - 1);

  logic [1:0] rst_sync;
  logic rst_b;
  state_s state_reg;
  state_s state_next;

  function automatic logic [15:0] ac_threshold(input logic [2:0] code);
    ac_threshold = AC_DISCONNECT_THRESHOLD_BASE + 16'(AC_DISCONNECT_THRESHOLD_STEP * code);
  endfunction

  // limit and overcurrent in mA for a select code; unused code gives zero
  function automatic logic [19:0] limit_lookup(input logic [2:0] code);
    unique case (code)
      3'b000: limit_lookup = {10'd420, 10'd370};
      3'b001: limit_lookup = {10'd720, 10'd634};
      3'b010: limit_lookup = {10'd126, 10'd111};
      3'b011: limit_lookup = {10'd223, 10'd196};
      3'b100: limit_lookup = {10'd0, 10'd0};
      3'b101: limit_lookup = {10'd850, 10'd748};
      3'b110: limit_lookup = {10'd900, 10'd792};
      3'b111: limit_lookup = {10'd950, 10'd836};
    endcase
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
    masked = (old & ~m) | (wd & m);
  endfunction

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b = rst_sync[1];

  logic tick;
  logic expire;
  logic wr_hit;
  logic [19:0] lim;

  always_comb begin
    state_next = state_reg;
    state_next.legacy_sync = {state_reg.legacy_sync[0], high_cap_sel_i};
    state_next.mode_load = 1'b0;
    state_next.power_on = 1'b0;
    tick = 1'b0;
    expire = 1'b0;
    wr_hit = reg_wr_i;
    lim = limit_lookup(state_reg.cfg.cur_limit[2:0]);

    // register writes
    if (wr_hit) begin
      unique case (reg_addr_i)
        WD_SWITCH_ADDR: state_next.cfg.wd_switch = masked(state_reg.cfg.wd_switch, reg_wdata_i, WD_SWITCH_MASK);
        WD_TIME_ADDR: state_next.cfg.wd_time = reg_wdata_i;
        PROGRAM_ADDR: state_next.cfg.program_cfg = masked(state_reg.cfg.program_cfg, reg_wdata_i, PROGRAM_MASK);
        PWM_ADDR: state_next.cfg.pwm = masked(state_reg.cfg.pwm, reg_wdata_i, PWM_MASK);
        MISC_TWO_ADDR: state_next.cfg.misc_two = masked(state_reg.cfg.misc_two, reg_wdata_i, MISC_TWO_MASK);
        CUR_LIMIT_ADDR: state_next.cfg.cur_limit = masked(state_reg.cfg.cur_limit, reg_wdata_i, CUR_LIMIT_MASK);
        default: ;
      endcase
    end
    // classification result overrides a software write in the same cycle
    if (class_load_i) begin
      state_next.cfg.cur_limit = {5'h00, class_code_i};
    end
    // select input holds the large-capacitor bit set while high
    if (state_reg.legacy_sync[1]) begin
      state_next.cfg.program_cfg[LARGE_CAP_BIT] = 1'b1;
    end

    // watchdog interval and counter
    if (state_reg.cfg.wd_switch[WD_ENABLE_BIT]) begin
      if (state_reg.tick_cnt == TICK_LAST) begin
        state_next.tick_cnt = 25'h000_0000;
        tick = 1'b1;
      end else begin
        state_next.tick_cnt = state_reg.tick_cnt + 25'h000_0001;
      end
    end else begin
      state_next.tick_cnt = 25'h000_0000;
    end
    // a software reload in the tick cycle wins over the decrement
    if (tick && !(wr_hit && reg_addr_i == WD_TIME_ADDR)) begin
      if (state_reg.cfg.wd_time != 8'h00) begin
        state_next.cfg.wd_time = state_reg.cfg.wd_time - 8'h01;
      end
      expire = (state_reg.cfg.wd_time <= 8'h01) && !state_reg.hw_mode;
    end
    if (expire) begin
      state_next.hw_mode = 1'b1;
      state_next.mode_load = 1'b1;
      state_next.port_mode = state_reg.cfg.wd_switch[EXPIRY_MODE_BIT] ? MODE_AUTO : MODE_SHUTDOWN;
    end
    // disabling the watchdog hands the port back to software
    if (!state_next.cfg.wd_switch[WD_ENABLE_BIT]) begin
      state_next.hw_mode = 1'b0;
    end

    // power-on requests are refused under hardware control
    if (power_on_req_i) begin
      if (state_reg.hw_mode) begin
        state_next.hw_control_flag = 1'b1;
      end else begin
        state_next.power_on = 1'b1;
      end
    end

    // register reads; the flag clears on read but a new set wins
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        HW_FLAG_ADDR: state_next.rdata = {7'h00, state_reg.hw_control_flag};
        WD_TIME_ADDR: state_next.rdata = state_reg.cfg.wd_time;
        WD_SWITCH_ADDR: state_next.rdata = state_reg.cfg.wd_switch;
        PROGRAM_ADDR: state_next.rdata = state_reg.cfg.program_cfg;
        PWM_ADDR: state_next.rdata = state_reg.cfg.pwm;
        MISC_TWO_ADDR: state_next.rdata = state_reg.cfg.misc_two;
        CUR_LIMIT_ADDR: state_next.rdata = state_reg.cfg.cur_limit;
        default: state_next.rdata = 8'h00;
      endcase
      if (reg_addr_i == HW_FLAG_ADDR && !expire && !(power_on_req_i && state_reg.hw_mode)) begin
        state_next.hw_control_flag = 1'b0;
      end
    end
    if (expire) begin
      state_next.hw_control_flag = 1'b1;
    end

    state_next.irq = state_next.hw_control_flag && state_next.cfg.wd_switch[EXPIRY_IRQ_BIT];
    state_next.power_allow = !state_next.hw_mode
      && (!det_bypassed_i || state_next.cfg.program_cfg[DET_SKIP_BIT]);
    if (ac_peak_valid_i) begin
      state_next.ac_present = ac_peak_i > ac_threshold(state_reg.cfg.program_cfg[2:0]);
    end
    state_next.limit_ma = lim[19:10];
    state_next.overcurrent_ma = lim[9:0];
  end

  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.cfg.wd_switch <= WD_SWITCH_RESET;
      state_reg.cfg.program_cfg <= PROGRAM_RESET;
      state_reg.cfg.pwm <= PWM_RESET;
      state_reg.cfg.misc_two <= MISC_TWO_RESET;
      state_reg.cfg.cur_limit <= CUR_LIMIT_RESET;
      state_reg.limit_ma <= 10'd420;
      state_reg.overcurrent_ma <= 10'd370;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o = state_reg.rdata;
  assign irq_o = state_reg.irq;
  assign port_mode_load_o = state_reg.mode_load;
  assign port_mode_o = state_reg.port_mode;
  assign power_on_o = state_reg.power_on;
  assign power_allow_o = state_reg.power_allow;
  assign ac_present_o = state_reg.ac_present;
  assign watchdog_enable_o = state_reg.cfg.wd_switch[WD_ENABLE_BIT];
  assign large_cap_detect_enable_o = state_reg.cfg.program_cfg[LARGE_CAP_BIT];
  assign limit_duty_select_o = state_reg.cfg.pwm[DUTY_LSB+1:DUTY_LSB];
  assign load_stability_check_enable_o = state_reg.cfg.misc_two[LOAD_CHECK_BIT];
  assign current_limit_ma_o = state_reg.limit_ma;
  assign overcurrent_ma_o = state_reg.overcurrent_ma;

  default clocking cb @(posedge mclk_i); endclocking
  // the pin also gates the checks, so the unknown state before the first edge is never judged
  default disable iff (!rst_b_i || !rst_b);

  wd_disabled_a: assert property (!watchdog_enable_o |=> !port_mode_load_o)
    else $error("port mode loaded while watchdog disabled");
  irq_gate_a: assert property (irq_o |-> state_reg.hw_control_flag && state_reg.cfg.wd_switch[EXPIRY_IRQ_BIT])
    else $error("interrupt without enabled flag");
  expiry_mode_a: assert property (expire |=> port_mode_load_o
    && port_mode_o == ($past(state_reg.cfg.wd_switch[0]) ? 2'b11 : 2'b00))
    else $error("wrong port mode on expiry");
  mode_code_a: assert property (port_mode_load_o |-> port_mode_o inside {2'b00, 2'b11})
    else $error("illegal expiry mode code");
  wd_decrement_a: assert property (tick && !wr_hit && state_reg.cfg.wd_time != 8'h00
    |=> state_reg.cfg.wd_time == $past(state_reg.cfg.wd_time) - 8'h01)
    else $error("watchdog counter did not decrement");
  irq_follow_a: assert property (expire && state_reg.cfg.wd_switch[6] && !wr_hit |=> irq_o)
    else $error("no interrupt after expiry");
  program_reset_a: assert property ($rose(rst_b) |-> state_reg.cfg.program_cfg == 8'h04)
    else $error("program register reset value wrong");
  large_cap_a: assert property (state_reg.legacy_sync[1] |=> large_cap_detect_enable_o)
    else $error("select input did not set large cap bit");
  skip_refuse_a: assert property (det_bypassed_i && !state_next.cfg.program_cfg[4] |=> !power_allow_o)
    else $error("power allowed after bypassed detection");
  ac_compare_a: assert property (ac_peak_valid_i && ac_peak_i <= 16'd8528 |=> !ac_present_o)
    else $error("presence below least threshold");
  duty_write_a: assert property (reg_wr_i && reg_addr_i == 8'h24
    |=> limit_duty_select_o == $past(reg_wdata_i[5:4]))
    else $error("duty select not written");
  misc_bits_a: assert property (state_reg.cfg.misc_two[7:5] == 3'b000 && state_reg.cfg.misc_two[1:0] == 2'b00)
    else $error("unconnected misc bits set");
  class_load_a: assert property (class_load_i |=> state_reg.cfg.cur_limit == {5'h00, $past(class_code_i)})
    else $error("classification code not loaded");
  limit_map_a: assert property (state_reg.cfg.cur_limit[2:0] == 3'b111 |=> current_limit_ma_o == 10'd950)
    else $error("current limit mapping wrong");
  load_check_a: assert property (reg_wr_i && reg_addr_i == 8'h29
    |=> load_stability_check_enable_o == $past(reg_wdata_i[4]))
    else $error("load check bit not written");

  flag_set_a: assert property (expire |=> state_reg.hw_control_flag)
    else $error("flag not set on expiry");
  power_refused_a: assert property (power_on_req_i && state_reg.hw_mode
    |=> !power_on_o && state_reg.hw_control_flag)
    else $error("power request passed under hardware control");
  mode_pulse_a: assert property (port_mode_load_o |=> !port_mode_load_o)
    else $error("expiry pulse longer than one cycle");
  wd_hw_idle_a: assert property (!watchdog_enable_o |=> !state_reg.hw_mode)
    else $error("hardware control while watchdog disabled");
  wd_hold_a: assert property (!tick && !wr_hit
    |=> state_reg.cfg.wd_time == $past(state_reg.cfg.wd_time))
    else $error("watchdog counter moved between ticks");
  large_cap_write_a: assert property (reg_wr_i && reg_addr_i == 8'h23 && !state_reg.legacy_sync[1]
    |=> large_cap_detect_enable_o == $past(reg_wdata_i[5]))
    else $error("large cap bit not written");
  ac_hold_a: assert property (!ac_peak_valid_i |=> $stable(ac_present_o))
    else $error("presence changed without a sensed peak");

  // reserved bits that are not connected can never hold a one
  switch_bits_a: assert property (state_reg.cfg.wd_switch[5:1] == 5'h00)
    else $error("unconnected switch bits set");
  program_bit_a: assert property (state_reg.cfg.program_cfg[3] == 1'b0)
    else $error("unconnected program bit set");
  pwm_bits_a: assert property (state_reg.cfg.pwm[7:6] == 2'b00)
    else $error("unconnected pwm bits set");
  limit_bits_a: assert property (state_reg.cfg.cur_limit[7:3] == 5'h00)
    else $error("unconnected limit bits set");
  unmapped_read_a: assert property (reg_rd_i && !(reg_addr_i inside {8'h1c, 8'h1e, 8'h1f, 8'h23, 8'h24, 8'h29, 8'h2a})
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped register read nonzero");

  expiry_auto_c: cover property (port_mode_load_o && port_mode_o == 2'b11);
  expiry_irq_c: cover property (expire ##1 irq_o);
  denied_power_c: cover property (power_on_req_i && state_reg.hw_mode);
  ac_present_c: cover property ($rose(ac_present_o));
  flag_read_c: cover property (reg_rd_i && reg_addr_i == 8'h1c && state_reg.hw_control_flag);
endmodule

// ===== testbench/tb_pse_port_config_registers.sv
// self-checking testbench of the port configuration register bank
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_pse_port_config_registers;
  import pse_cfg_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, high_cap_sel_i = 1'b0, power_on_req_i = 1'b0;
  logic det_bypassed_i = 1'b0, class_load_i = 1'b0, ac_peak_valid_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rd_val;
  logic [2:0] class_code_i = 3'h0;
  logic [15:0] ac_peak_i = 16'h0000;
  logic irq_o, port_mode_load_o, power_on_o, power_allow_o, ac_present_o, watchdog_enable_o;
  logic large_cap_detect_enable_o, load_stability_check_enable_o;
  logic [1:0] port_mode_o, limit_duty_select_o;
  logic [9:0] current_limit_ma_o, overcurrent_ma_o;
  int miscompares = 0;
  int check_count = 0;
  logic [9:0] lim_tab [8] = '{10'd420, 10'd720, 10'd126, 10'd223, 10'd0, 10'd850, 10'd900, 10'd950};
  logic [9:0] oc_tab [8] = '{10'd370, 10'd634, 10'd111, 10'd196, 10'd0, 10'd748, 10'd792, 10'd836};
  logic [7:0] map_addr [4] = '{PROGRAM_ADDR, PWM_ADDR, MISC_TWO_ADDR, CUR_LIMIT_ADDR};
  // internally connected reserved bits are always written as zero
  logic [7:0] map_wr [4] = '{8'h3f, 8'hf0, 8'hf3, 8'hff};
  logic [7:0] map_exp [4] = '{8'h37, 8'h30, 8'h10, 8'h07};
  logic [7:0] map_rst [4] = '{8'h04, 8'h00, 8'h00, 8'h00};

  always #4 mclk_i = ~mclk_i;

  // a short tick keeps each watchdog step to a handful of cycles
  pse_port_config_registers #(.WD_TICK(8)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .high_cap_sel_i(high_cap_sel_i), .power_on_req_i(power_on_req_i), .det_bypassed_i(det_bypassed_i),
    .class_load_i(class_load_i), .class_code_i(class_code_i), .ac_peak_valid_i(ac_peak_valid_i),
    .ac_peak_i(ac_peak_i), .irq_o(irq_o), .port_mode_load_o(port_mode_load_o), .port_mode_o(port_mode_o),
    .power_on_o(power_on_o), .power_allow_o(power_allow_o), .ac_present_o(ac_present_o),
    .watchdog_enable_o(watchdog_enable_o), .large_cap_detect_enable_o(large_cap_detect_enable_o),
    .limit_duty_select_o(limit_duty_select_o),
    .load_stability_check_enable_o(load_stability_check_enable_o),
    .current_limit_ma_o(current_limit_ma_o), .overcurrent_ma_o(overcurrent_ma_o));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic pwr_req(input logic exp);
    @(posedge mclk_i);
    power_on_req_i <= 1'b1;
    @(posedge mclk_i);
    power_on_req_i <= 1'b0;
    #1;
    `CHK("power_on", exp, power_on_o)
  endtask

  // waits a bounded time for the expiry pulse; a missing pulse ends the run
  task automatic wait_expiry();
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk_i);
      #1;
      if (port_mode_load_o === 1'b1) break;
    end
    if (n == 60) begin
      miscompares++;
      $display("mismatch expiry_pulse expected 1 seen 0");
      wrap_up();
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    int k;
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (k = 0; k < 4; k++) begin
      rd(map_addr[k], rd_val);
      `CHK("reset_value", map_rst[k], rd_val)
    end
    rd(WD_SWITCH_ADDR, rd_val);
    `CHK("switch_reset", 8'h00, rd_val)
    `CHK("limit_reset", 10'd420, current_limit_ma_o)
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      wr(map_addr[k], map_wr[k]);
      rd(map_addr[k], rd_val);
      `CHK("write_mask", map_exp[k], rd_val)
    end
    `CHK("load_check", 1'b1, load_stability_check_enable_o)
    wr(8'h25, 8'h00);
    wr(8'h32, 8'hff);
    rd(8'h32, rd_val);
    `CHK("unmapped", 8'h00, rd_val)
    wr(WD_SWITCH_ADDR, 8'h3e);
    rd(WD_SWITCH_ADDR, rd_val);
    `CHK("switch_reserved", 8'h00, rd_val)
    $display("test masks done");
    for (k = 0; k < 4; k++) begin
      wr(PWM_ADDR, {2'b00, k[1:0], 4'h0});
      `CHK("duty", k[1:0], limit_duty_select_o)
    end
    for (k = 0; k < 8; k++) begin
      // software never selects the unused code
      if (k == 4) continue;
      wr(CUR_LIMIT_ADDR, {5'h00, k[2:0]});
      @(posedge mclk_i);
      #1;
      `CHK("limit", lim_tab[k], current_limit_ma_o)
      `CHK("overcurrent", oc_tab[k], overcurrent_ma_o)
    end
    @(posedge mclk_i);
    class_load_i <= 1'b1;
    class_code_i <= 3'b011;
    @(posedge mclk_i);
    class_load_i <= 1'b0;
    rd(CUR_LIMIT_ADDR, rd_val);
    `CHK("class_load", 8'h03, rd_val)
    `CHK("class_limit", 10'd223, current_limit_ma_o)
    $display("test limits done");
    wr(PROGRAM_ADDR, 8'h02);
    high_cap_sel_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    `CHK("large_cap_pin", 1'b1, large_cap_detect_enable_o)
    high_cap_sel_i <= 1'b0;
    // let the synchroniser drain, or the pin sets the bit again after the write
    repeat (2) @(posedge mclk_i);
    wr(PROGRAM_ADDR, 8'h02);
    repeat (4) @(posedge mclk_i);
    #1;
    `CHK("large_cap_sw", 1'b0, large_cap_detect_enable_o)
    det_bypassed_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("allow_noskip", 1'b0, power_allow_o)
    wr(PROGRAM_ADDR, 8'h12);
    @(posedge mclk_i);
    #1;
    `CHK("allow_skip", 1'b1, power_allow_o)
    for (k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      ac_peak_valid_i <= 1'b1;
      ac_peak_i <= 16'd8528 + 16'd1064 * 16'd2 + 16'(k);
      @(posedge mclk_i);
      ac_peak_valid_i <= 1'b0;
      #1;
      `CHK("ac_present", k[0], ac_present_o)
    end
    $display("test program done");
    wr(WD_TIME_ADDR, 8'h01);
    wr(WD_SWITCH_ADDR, 8'h41);
    for (k = 0; k < 40; k++) begin
      @(posedge mclk_i);
      #1;
      `CHK("no_expiry", 1'b0, port_mode_load_o)
    end
    pwr_req(1'b1);
    wr(WD_SWITCH_ADDR, 8'hc1);
    wait_expiry();
    `CHK("mode_auto", MODE_AUTO, port_mode_o)
    @(posedge mclk_i);
    #1;
    `CHK("irq_on", 1'b1, irq_o)
    rd(HW_FLAG_ADDR, rd_val);
    `CHK("flag", 8'h01, rd_val)
    @(posedge mclk_i);
    #1;
    `CHK("irq_cleared", 1'b0, irq_o)
    pwr_req(1'b0);
    @(posedge mclk_i);
    #1;
    `CHK("irq_refused", 1'b1, irq_o)
    wr(WD_SWITCH_ADDR, 8'h00);
    rd(HW_FLAG_ADDR, rd_val);
    wr(WD_TIME_ADDR, 8'h02);
    wr(WD_SWITCH_ADDR, 8'h80);
    wait_expiry();
    `CHK("mode_shutdown", MODE_SHUTDOWN, port_mode_o)
    @(posedge mclk_i);
    #1;
    `CHK("irq_masked", 1'b0, irq_o)
    $display("test watchdog done");
    wrap_up();
  end
endmodule
